// [src/ict_core.v]
// Instruction sequencer and data path of an 8-bit core
`timescale 1ns/10ps
`include "ict_map.vh"

// Notes on behaviour
// [RL1] One instruction cycle is four system clocks and all execution steps in these units.
// [RL2] Ordinary instructions finish in one cycle; branch, call and table read take two.
// [RL3] Goto, call, return, interrupt return and table read add one cycle, two in total.
// [RL4] Any write to the program counter low byte costs one extra cycle.
// [RL5] A write to the program counter low byte jumps there and drops the prefetched word.
// [RL6] A skip takes one cycle when not taken and one more when it skips.
// [RL7] Transfers run memory to accumulator, accumulator to memory, and immediate to accumulator.
// [RL8] Add sets carry above 255 and subtract clears carry (borrow) below 0.
// [RL9] Increment and decrement change the operand by one, into memory or accumulator.
// [RL10] Logical operations set zero when the 8-bit result is zero and clear it otherwise.
// [RL11] Logical operations always pass through the accumulator; INV writes its result to data memory instead.
// [RL12] Rotates shift exactly one bit in the chosen direction.
// [RL13] Rotates via carry move the lost bit into carry and old carry into the freed bit.
// [RL14] Add and subtract update zero, carry, auxiliary carry and overflow.
// [RL15] Two-cycle instructions stall fetch one cycle; the extra cycle changes no accumulator, flag or memory, only the table read word.
module ict_core (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // Program memory
   output reg  [10:0] o_pm_addr,
   input  wire [13:0] i_pm_data,
   // Data memory
   output reg  [7:0]  o_dm_addr,
   output reg  [7:0]  o_dm_wdata,
   output reg         o_dm_we,
   input  wire [7:0]  i_dm_rdata,
   // Status
   output reg  [7:0]  o_acc,
   output reg  [3:0]  o_flags,
   output reg         o_stall,
   output reg  [7:0]  o_tbl_data,
   output reg  [1:0]  o_phase
);

   // ----------------------------------------
   // Phase and state
   // ----------------------------------------
   localparam ST_EXEC  = 1'b0;
   localparam ST_DUMMY = 1'b1;

   reg  [10:0] pc;
   reg  [13:0] ir;
   reg         state;
   reg  [1:0]  sp;
   // Four deep return stack; a fifth call overwrites the oldest entry
   reg  [10:0] stack [0:3];
   reg         zf;
   reg         cf;
   reg         acf;
   reg         ovf;
   reg  [10:0] dummy_pc;
   reg         tbl_wait;

   wire [5:0]  op   = ir[`ICT_OP_HI:`ICT_OP_LO];
   wire [7:0]  arg  = ir[`ICT_ARG_HI:`ICT_ARG_LO];
   wire        last = (o_phase == `ICT_PH_LAST);

   // ----------------------------------------
   // Arithmetic helper
   // ----------------------------------------
   // Returns {ov, ac, c, result}; subtract forms a + ~b + cin
   function [10:0] ict_alu;
      input [7:0] a;
      input [7:0] b;
      input       sub;
      input       cin;
      reg   [7:0] bb;
      reg   [8:0] s;
      reg   [4:0] h;
      begin
         bb = sub ? ~b : b;
         s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
         h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
         ict_alu = {(a[7] == bb[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
      end
   endfunction

   // ----------------------------------------
   // Fetch address step
   // ----------------------------------------
   function [10:0] ict_step;
      input [10:0] addr;
      begin
         ict_step = addr + 11'h001;
      end
   endfunction

   // ----------------------------------------
   // Decode and execute
   // ----------------------------------------
   reg  [7:0]  res;
   reg  [10:0] al;
   reg         wr_acc;
   reg         wr_mem;
   reg         two;
   reg         jump;
   reg  [10:0] target;
   reg         upd_z;
   reg         upd_arith;
   reg         next_c;
   reg         push;
   reg         pop;

   always @* begin
      res = 8'h00;
      al = 11'h000;
      wr_acc = 1'b0;
      wr_mem = 1'b0;
      two = 1'b0;
      jump = 1'b0;
      target = pc;
      upd_z = 1'b0;
      upd_arith = 1'b0;
      next_c = cf;
      push = 1'b0;
      pop = 1'b0;
      case (op)
         `ICT_OP_MOVAM: begin res = i_dm_rdata; wr_acc = 1'b1; end       // RL7
         `ICT_OP_MOVMA: begin res = o_acc; wr_mem = 1'b1; end            // RL7
         `ICT_OP_MOVAX: begin res = arg; wr_acc = 1'b1; end              // RL7
         `ICT_OP_ADDM, `ICT_OP_ADDX, `ICT_OP_ADCM, `ICT_OP_ADDMEM: begin
            al = ict_alu(o_acc, (op == `ICT_OP_ADDX) ? arg : i_dm_rdata, 1'b0,
                         (op == `ICT_OP_ADCM) & cf);                     // RL8
            res = al[7:0];
            upd_arith = 1'b1;                                            // RL14
            wr_mem = (op == `ICT_OP_ADDMEM);
            wr_acc = ~wr_mem;
         end
         `ICT_OP_SUBM, `ICT_OP_SUBX, `ICT_OP_SBCM, `ICT_OP_SUBMEM: begin
            al = ict_alu(o_acc, (op == `ICT_OP_SUBX) ? arg : i_dm_rdata, 1'b1,
                         (op == `ICT_OP_SBCM) ? cf : 1'b1);              // RL8
            res = al[7:0];
            upd_arith = 1'b1;                                            // RL14
            wr_mem = (op == `ICT_OP_SUBMEM);
            wr_acc = ~wr_mem;
         end
         `ICT_OP_AND:  begin res = o_acc & i_dm_rdata; wr_acc = 1'b1; upd_z = 1'b1; end   // RL11
         `ICT_OP_OR:   begin res = o_acc | i_dm_rdata; wr_acc = 1'b1; upd_z = 1'b1; end   // RL11
         `ICT_OP_XOR:  begin res = o_acc ^ i_dm_rdata; wr_acc = 1'b1; upd_z = 1'b1; end   // RL11
         `ICT_OP_ANDX: begin res = o_acc & arg; wr_acc = 1'b1; upd_z = 1'b1; end
         `ICT_OP_ORX:  begin res = o_acc | arg; wr_acc = 1'b1; upd_z = 1'b1; end
         `ICT_OP_XORX: begin res = o_acc ^ arg; wr_acc = 1'b1; upd_z = 1'b1; end
         `ICT_OP_INV:  begin res = ~i_dm_rdata; wr_mem = 1'b1; upd_z = 1'b1; end
         `ICT_OP_INVA: begin res = ~i_dm_rdata; wr_acc = 1'b1; upd_z = 1'b1; end
         `ICT_OP_INC:  begin res = i_dm_rdata + 8'h01; wr_mem = 1'b1; upd_z = 1'b1; end   // RL9
         `ICT_OP_ADD_ONE_TO_ACC: begin res = i_dm_rdata + 8'h01; wr_acc = 1'b1; upd_z = 1'b1; end   // RL9
         `ICT_OP_DECM: begin res = i_dm_rdata - 8'h01; wr_mem = 1'b1; upd_z = 1'b1; end   // RL9
         `ICT_OP_DECAM: begin res = i_dm_rdata - 8'h01; wr_acc = 1'b1; upd_z = 1'b1; end  // RL9
         `ICT_OP_ROR:  begin res = {i_dm_rdata[0], i_dm_rdata[7:1]}; wr_mem = 1'b1; end   // RL12
         `ICT_OP_ROL:  begin res = {i_dm_rdata[6:0], i_dm_rdata[7]}; wr_mem = 1'b1; end   // RL12
         `ICT_OP_RORC: begin
            res = {cf, i_dm_rdata[7:1]};                                 // RL13
            next_c = i_dm_rdata[0];                                      // RL13
            wr_mem = 1'b1;
         end
         `ICT_OP_ROLC: begin
            res = {i_dm_rdata[6:0], cf};                                 // RL13
            next_c = i_dm_rdata[7];                                      // RL13
            wr_mem = 1'b1;
         end
         `ICT_OP_CLRM: begin res = 8'h00; wr_mem = 1'b1; end
         // A taken skip refetches past the skipped word in the inserted cycle
         `ICT_OP_SZ:   two = (i_dm_rdata == 8'h00);                      // RL6
         `ICT_OP_SNZ:  two = (i_dm_rdata != 8'h00);                      // RL6
         `ICT_OP_TBL:  two = 1'b1;                                       // RL3
         `ICT_OP_RET, `ICT_OP_INTERRUPT_EXIT: begin
            two = 1'b1;                                                  // RL3
            jump = 1'b1;
            pop = 1'b1;
            target = stack[sp - 2'h1];
         end
         `ICT_OP_GOTO, `ICT_OP_CALL: begin
            two = 1'b1;                                                  // RL3
            jump = 1'b1;
            push = (op == `ICT_OP_CALL);
            target = {pc[10:8], arg};
         end
         default: ;
      endcase
      // A program counter low byte write is a jump
      if (wr_mem && (arg == `ICT_PCL_ADDR)) begin
         two = 1'b1;                                                     // RL4
         jump = 1'b1;                                                    // RL5
         target = {pc[10:8], res};                                       // RL5
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_phase <= 2'h0;
         pc <= `ICT_RST_PC;
         ir <= 14'h0000;
         state <= ST_EXEC;
         sp <= 2'h0;
         zf <= 1'b0;
         cf <= 1'b0;
         acf <= 1'b0;
         ovf <= 1'b0;
         dummy_pc <= 11'h000;
         tbl_wait <= 1'b0;
         o_acc <= `ICT_RST_DATA;
         o_flags <= 4'h0;
         o_stall <= 1'b0;
         o_tbl_data <= 8'h00;
         o_pm_addr <= `ICT_RST_PC;
         o_dm_addr <= 8'h00;
         o_dm_wdata <= 8'h00;
         o_dm_we <= 1'b0;
      end else begin
         o_phase <= o_phase + 2'h1;                                      // RL1
         o_dm_we <= 1'b0;
         // Port flags trail the internal ones by one clock
         o_flags <= {ovf, acf, cf, zf};
         if (o_phase == 2'h0) begin
            o_dm_addr <= arg;
         end
         if (last) begin
            case (state)
               ST_EXEC: begin
                  if (wr_acc) begin
                     o_acc <= res;
                  end
                  if (wr_mem) begin
                     o_dm_we <= 1'b1;
                     o_dm_wdata <= res;
                  end
                  if (upd_z || upd_arith) begin
                     zf <= (res == 8'h00);                               // RL10
                  end
                  if (upd_arith) begin
                     cf <= al[8];                                        // RL14
                     acf <= al[9];
                     ovf <= al[10];
                  end else begin
                     cf <= next_c;
                  end
                  if (push) begin
                     stack[sp] <= pc;
                     sp <= sp + 2'h1;
                  end
                  if (pop) begin
                     sp <= sp - 2'h1;
                  end
                  if (two && (op == `ICT_OP_TBL)) begin
                     // Table word is read in the inserted cycle; the
                     // prefetched next word waits in ir meanwhile
                     state <= ST_DUMMY;                                  // RL2
                     o_stall <= 1'b1;                                    // RL15
                     tbl_wait <= 1'b1;
                     ir <= i_pm_data;
                     pc <= ict_step(pc);
                     dummy_pc <= ict_step(pc);
                     o_pm_addr <= {pc[10:8], o_acc};                     // RL3
                  end else if (two) begin
                     // Fetch the target at once so that it runs straight
                     // after the inserted cycle, not one cycle later
                     state <= ST_DUMMY;                                  // RL2
                     o_stall <= 1'b1;                                    // RL15
                     if (jump) begin
                        dummy_pc <= target;
                        o_pm_addr <= target;
                     end else begin
                        dummy_pc <= ict_step(pc);
                        o_pm_addr <= ict_step(pc);                       // RL6
                     end
                     ir <= 14'h0000;                                     // RL5
                  end else begin
                     ir <= i_pm_data;
                     pc <= ict_step(pc);
                     o_pm_addr <= ict_step(pc);
                  end
               end
               ST_DUMMY: begin
                  // Inserted cycle only fetches and latches a table word; acc, flags and memory stay
                  state <= ST_EXEC;                                      // RL15
                  o_stall <= 1'b0;
                  tbl_wait <= 1'b0;
                  if (tbl_wait) begin
                     o_tbl_data <= i_pm_data[7:0];                       // RL3
                     pc <= dummy_pc;
                     o_pm_addr <= dummy_pc;
                  end else begin
                     ir <= i_pm_data;                                    // RL5
                     pc <= ict_step(dummy_pc);
                     o_pm_addr <= ict_step(dummy_pc);
                  end
               end
               default: state <= ST_EXEC;
            endcase
         end
      end
   end

endmodule // ict_core

// [src/ict_map.vh]
// Constants for the instruction cycle timing core
`ifndef ICT_MAP_VH
`define ICT_MAP_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define ICT_PHASES      4
`define ICT_PH_LAST     2'h3

// ----------------------------------------
// Opcode field layout (14-bit word)
// ----------------------------------------
`define ICT_OP_HI       13
`define ICT_OP_LO       8
`define ICT_ARG_HI      7
`define ICT_ARG_LO      0
`define ICT_BIT_HI      10
`define ICT_BIT_LO      8

// ----------------------------------------
// Operation codes (upper six bits)
// ----------------------------------------
`define ICT_OP_NOP      6'h00
`define ICT_OP_MOVAM    6'h01
`define ICT_OP_MOVMA    6'h02
`define ICT_OP_MOVAX    6'h03
`define ICT_OP_ADDM     6'h04
`define ICT_OP_ADDX     6'h05
`define ICT_OP_ADCM     6'h06
`define ICT_OP_SUBM     6'h07
`define ICT_OP_SUBX     6'h08
`define ICT_OP_SBCM     6'h09
`define ICT_OP_ADDMEM   6'h0a
`define ICT_OP_SUBMEM   6'h0b
`define ICT_OP_AND      6'h0c
`define ICT_OP_OR       6'h0d
`define ICT_OP_XOR      6'h0e
`define ICT_OP_ANDX     6'h0f
`define ICT_OP_ORX      6'h10
`define ICT_OP_XORX     6'h11
`define ICT_OP_INV      6'h12
`define ICT_OP_INVA     6'h13
`define ICT_OP_INC      6'h14
`define ICT_OP_ADD_ONE_TO_ACC     6'h15
`define ICT_OP_DECM     6'h16
`define ICT_OP_DECAM    6'h17
`define ICT_OP_ROR      6'h18
`define ICT_OP_ROL      6'h19
`define ICT_OP_RORC     6'h1a
`define ICT_OP_ROLC     6'h1b
`define ICT_OP_CLRM     6'h1c
`define ICT_OP_SZ       6'h1d
`define ICT_OP_SNZ      6'h1e
`define ICT_OP_TBL      6'h1f
`define ICT_OP_RET      6'h20
`define ICT_OP_INTERRUPT_EXIT     6'h21
`define ICT_OP_GOTO     6'h22
`define ICT_OP_CALL     6'h23

// ----------------------------------------
// Data memory map and reset values
// ----------------------------------------
`define ICT_PCL_ADDR    8'h06
`define ICT_RST_PC      11'h000
`define ICT_RST_DATA    8'h00

`endif

// [tb/ict_mem_model.sv]
// Program and data memory seen by the core
`timescale 1ns/10ps
module ict_mem_model (
   input  wire logic        i_clk,
   input  wire logic [10:0] i_pm_addr,
   output logic      [13:0] o_pm_data,
   input  wire logic [7:0]  i_dm_addr,
   input  wire logic [7:0]  i_dm_wdata,
   input  wire logic        i_dm_we,
   output logic      [7:0]  o_dm_rdata
);
   logic [13:0] rom [0:2047];
   logic [7:0]  ram [0:255];
   // Both reads are asynchronous; the core samples them late in the cycle
   assign o_pm_data = rom[i_pm_addr];
   assign o_dm_rdata = ram[i_dm_addr];
   always @(posedge i_clk) begin
      if (i_dm_we) begin
         ram[i_dm_addr] <= i_dm_wdata;
      end
   end
endmodule // ict_mem_model

// [tb/ict_core_properties.sv]
// Port checks for the instruction cycle core
`timescale 1ns/10ps
`include "ict_map.vh"
module ict_core_properties (
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic [10:0] o_pm_addr,
   input wire logic [7:0]  o_dm_addr,
   input wire logic [7:0]  o_dm_wdata,
   input wire logic        o_dm_we,
   input wire logic [7:0]  o_acc,
   input wire logic [3:0]  o_flags,
   input wire logic        o_stall,
   input wire logic [1:0]  o_phase
);
   logic [7:0] wr_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   always @(posedge i_clk) begin
      if (o_dm_we) begin
         wr_q <= o_dm_wdata;
      end
   end
   chk_phase_step: assert property ($past(i_rst_n) |=> o_phase == $past(o_phase) + 2'h1)
      else $error("phase skipped");
   chk_we_pulse: assert property (o_dm_we |-> o_phase == 2'h0 && $stable(o_dm_addr) ##1 !o_dm_we)
      else $error("bad write strobe");
   chk_stall_len: assert property ($rose(o_stall) |-> (o_phase == 2'h0 && o_stall) ##1 o_stall[*3] ##1 !o_stall)
      else $error("bad stall length");
   chk_stall_quiet: assert property (o_stall |=> $stable(o_acc) && !o_dm_we)
      else $error("change in inserted cycle");
   chk_acc_edge: assert property (!$stable(o_acc) |-> $past(o_phase) == 2'h3)
      else $error("acc moved mid cycle");
   chk_fetch_edge: assert property (!$stable(o_pm_addr) |-> $past(o_phase) == 2'h3)
      else $error("fetch moved mid cycle");
   chk_flag_lag: assert property (!$stable(o_flags) |-> o_phase == 2'h1)
      else $error("flags moved off slot");
   chk_pcl_jump: assert property (o_dm_we && o_dm_addr == `ICT_PCL_ADDR |->
      o_stall ##[1:5] o_pm_addr[7:0] == wr_q)
      else $error("no jump on low byte write");
   cover property ($rose(o_stall));
   cover property (o_dm_we && o_dm_addr == `ICT_PCL_ADDR);
   cover property ($rose(o_flags[1]));
endmodule // ict_core_properties
bind ict_core ict_core_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_pm_addr(o_pm_addr),
   .o_dm_addr(o_dm_addr), .o_dm_wdata(o_dm_wdata), .o_dm_we(o_dm_we), .o_acc(o_acc),
   .o_flags(o_flags), .o_stall(o_stall), .o_phase(o_phase));

// [tb/instruction_cycle_timing_tb_top.sv]
// Self-checking bench for the instruction cycle core
`timescale 1ns/10ps
`include "ict_map.vh"
module instruction_cycle_timing_tb_top;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [10:0] pa;
   logic [13:0] pd;
   logic [7:0]  da, dw, dr, acc, tbl;
   logic [3:0]  flags;
   logic        we, stall;
   logic [1:0]  phase;
   logic [13:0] prog [0:19];
   int          fails = 0;
   int          total_checks = 0;
   int          cycles = 0;
   always #2 i_clk = ~i_clk;
   ict_core i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_pm_addr(pa), .i_pm_data(pd), .o_dm_addr(da),
      .o_dm_wdata(dw), .o_dm_we(we), .i_dm_rdata(dr), .o_acc(acc), .o_flags(flags), .o_stall(stall),
      .o_tbl_data(tbl), .o_phase(phase));
   ict_mem_model i_mem (.i_clk(i_clk), .i_pm_addr(pa), .o_pm_data(pd), .i_dm_addr(da),
      .i_dm_wdata(dw), .i_dm_we(we), .o_dm_rdata(dr));
   task check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Reset mid-run on purpose, load the program, release
   task boot;
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      for (int k = 0; k < 2048; k++) begin
         i_mem.rom[k] = (k < 20) ? prog[k] : 14'h0000;
      end
      for (int k = 0; k < 256; k++) begin
         i_mem.ram[k] = 8'h00;
      end
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
   endtask
   // Clocks until the accumulator shows v; 0x40 means never
   task wait_acc(input logic [7:0] v, output logic [7:0] n);
      n = 8'h00;
      while (acc !== v && n < 8'h40) begin
         @(posedge i_clk);
         #1;
         n++;
      end
   endtask
   task t_timing;
      logic [7:0] n;
      prog = '{{`ICT_OP_MOVAX, 8'h01}, {`ICT_OP_MOVAX, 8'h02}, {`ICT_OP_GOTO, 8'h06}, {`ICT_OP_MOVAX, 8'hee},
         {`ICT_OP_MOVAX, 8'h0f}, {`ICT_OP_RET, 8'h00}, {`ICT_OP_MOVAX, 8'h0a},
         {`ICT_OP_MOVMA, `ICT_PCL_ADDR}, {`ICT_OP_MOVAX, 8'hee},
         14'h0000, {`ICT_OP_MOVAX, 8'h0b}, {`ICT_OP_SZ, 8'h40}, {`ICT_OP_MOVAX, 8'hee}, {`ICT_OP_MOVAX, 8'h0c},
         {`ICT_OP_SNZ, 8'h40}, {`ICT_OP_MOVAX, 8'h0d}, {`ICT_OP_TBL, 8'h00}, {`ICT_OP_MOVAX, 8'h0e},
         {`ICT_OP_CALL, 8'h04}, {`ICT_OP_MOVAX, 8'h10}};
      boot;
      wait_acc(8'h01, n);
      wait_acc(8'h02, n);
      check(n, 8'h04);
      wait_acc(8'h0a, n);
      check(n, 8'h0c);
      wait_acc(8'h0b, n);
      check(n, 8'h0c);
      wait_acc(8'h0c, n);
      check(n, 8'h0c);
      wait_acc(8'h0d, n);
      check(n, 8'h08);
      wait_acc(8'h0e, n);
      check(n, 8'h0c);
      check(tbl, 8'h0c);
      wait_acc(8'h0f, n);
      check(n, 8'h0c);
      wait_acc(8'h10, n);
      check(n, 8'h0c);
      $display("timing test done");
   endtask
   task t_alu;
      logic [7:0] n;
      logic [7:0] ea [0:17];
      logic [7:0] ef [0:17];
      prog = '{{`ICT_OP_MOVAX, 8'h10}, {`ICT_OP_ADDM, 8'h30}, {`ICT_OP_SUBX, 8'h01}, {`ICT_OP_MOVAX, 8'h7f},
         {`ICT_OP_ADDX, 8'h11}, {`ICT_OP_MOVMA, 8'h33}, {`ICT_OP_MOVAM, 8'h31}, {`ICT_OP_ADD_ONE_TO_ACC, 8'h33},
         {`ICT_OP_DECM, 8'h31}, {`ICT_OP_DECAM, 8'h32}, {`ICT_OP_OR, 8'h30}, {`ICT_OP_ANDX, 8'h0f},
         {`ICT_OP_XOR, 8'h30}, {`ICT_OP_INVA, 8'h32}, {`ICT_OP_RORC, 8'h34}, {`ICT_OP_ROLC, 8'h38},
         {`ICT_OP_ROR, 8'h36}, {`ICT_OP_ROL, 8'h37}, {`ICT_OP_INV, 8'h31}, 14'h0000};
      ea = '{8'h00, 8'hff, 8'h7f, 8'h90, 8'h90, 8'h20, 8'h91, 8'h91, 8'h00, 8'hf0, 8'h00, 8'hf0,
         8'hfe, 8'hfe, 8'hfe, 8'hfe, 8'hfe, 8'hfe};
      // Upper nibble masks the flags that each step defines
      ef = '{8'hf3, 8'h30, 8'h00, 8'hfc, 8'h00, 8'h00, 8'h10, 8'h10, 8'h11, 8'h10, 8'h11, 8'h10,
         8'h10, 8'h22, 8'h20, 8'h20, 8'h20, 8'h10};
      boot;
      i_mem.ram[8'h30] = 8'hf0;
      i_mem.ram[8'h31] = 8'h20;
      i_mem.ram[8'h32] = 8'h01;
      i_mem.ram[8'h34] = 8'h81;
      i_mem.ram[8'h36] = 8'h81;
      i_mem.ram[8'h37] = 8'h81;
      i_mem.ram[8'h38] = 8'h40;
      wait_acc(8'h10, n);
      @(posedge i_clk);
      for (int i = 0; i < 18; i++) begin
         repeat (4) @(posedge i_clk);
         #1;
         check(acc, ea[i]);
         check({4'h0, flags & ef[i][7:4]}, {4'h0, ef[i][3:0]});
      end
      repeat (4) @(posedge i_clk);
      check(i_mem.ram[8'h33], 8'h90);
      check(i_mem.ram[8'h31], 8'he0);
      check(i_mem.ram[8'h34], 8'h40);
      check(i_mem.ram[8'h38], 8'h81);
      check(i_mem.ram[8'h36], 8'hc0);
      check(i_mem.ram[8'h37], 8'h03);
      $display("data test done");
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         stop_test;
      end
   end
   initial begin
      t_timing;
      t_alu;
      stop_test;
   end
endmodule // instruction_cycle_timing_tb_top
